// [src/spcd_top.sv]
`timescale 1ns/1ps

// Behaviour
// [RL1] One 8-bit counter, timer or watchdog, never both
// [RL2] Option bits 3:0 choose owner and ratio
// [RL3] Timer register write clears counter when timer-owned
// [RL4] Watchdog clear clears counter and watchdog count; code clears the counter only when watchdog-owned
// [RL5] Counter value never readable nor writable
// [RL6] Any device reset leaves counter all zeros
// [RL7] Owner may change any time while running
// [RL8] Software sequence for timer-to-watchdog handover
// [RL9] Software sequence for watchdog-to-timer handover
// [RL10] Watchdog off only by fuse, own RC clock
// [RL11] Startup delay every reset crystal, power-up RC
// [RL12] Sleep ends on pin change or watchdog timeout
// [RL13] Twelve-bit configuration word with five fields
// [RL14] Bit 5 picks reset pin or digital I/O
// [RL15] Bit 3 enables the watchdog
// [RL16] Oscillator field decodes to eight documented modes
// [RL17] Programmer writes all protection bits equal
// [RL18] Configuration at 0FFFh, hidden from running code
// [RL19] Location 03FFh never code protected
// [RL20] Crystal modes accept external clock on input
// [RL21] Timer-owned counter divides 1:2 up to 1:256
// [RL22] Power-of-two ratios per owner from field
module spcd_top #(
  parameter int DRT_CYCLES = spcd_pkg::DRT_CYCLES_DFLT,
  parameter int WDT_RC_DIV = spcd_pkg::WDT_RC_DIV_DFLT,
  parameter int WDT_BASE_TICKS = spcd_pkg::WDT_BASE_TICKS_DFLT,
  parameter int WDT_CNT_W = 8
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [spcd_pkg::AVS_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [spcd_pkg::CFG_W-1:0] CONFIG_WORD,
  input wire logic INSTR_TICK,
  input wire logic TIMER_PIN,
  input wire logic TIMER_COUNT_WRITE,
  input wire logic WATCHDOG_CLEAR_INSTR,
  input wire logic SLEEP_ENTER,
  input wire logic PIN_CHANGE,
  input wire logic MASTER_CLEAR_N_PIN,
  input wire logic [spcd_pkg::PADDR_W-1:0] USER_ADDR,
  input wire logic [spcd_pkg::PADDR_W-1:0] PROG_ADDR,
  output logic TIMER_INC,
  output logic WDT_TIMEOUT,
  output logic CHIP_RESET_N,
  output logic SLEEPING,
  output logic WAKE,
  output spcd_pkg::spcd_osc_t OSC_MODE,
  output logic OSC_SELECT_INVALID,
  output logic CLOCK_OUTPUT_EN,
  output logic CRYSTAL_MODE,
  output logic RESET_PIN_IO,
  output logic WDT_ACTIVE,
  output logic USER_ADDR_OK,
  output logic PROG_READ_OK
);

  localparam int DRT_W = $clog2(DRT_CYCLES + 1);
  localparam int RC_W = $clog2(WDT_RC_DIV + 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  spcd_pkg::spcd_cfg_t cfg_r;
  spcd_pkg::spcd_opt_t opt_r;
  spcd_pkg::spcd_rst_t state_r;
  logic [spcd_pkg::PRESC_W-1:0] presc_r;
  logic [spcd_pkg::PRESC_W-1:0] presc_mask;
  logic [WDT_CNT_W-1:0] wdt_cnt_r;
  logic [RC_W-1:0] rc_div_r;
  logic [DRT_W-1:0] drt_cnt_r;
  logic por_r;
  logic ack_r;
  logic sleep_r;
  logic wake_r;
  logic tinc_r;
  logic wto_r;
  logic pin_prev_r;
  logic user_ok_r;
  logic prog_ok_r;
  logic [31:0] rdata_r;
  logic run;
  logic crystal;
  logic master_clear_input_active;
  logic rc_tick;
  logic wdt_on;
  logic wdt_ovf;
  logic wdt_evt;
  logic timer_src;
  logic presc_evt;
  logic presc_tc;
  logic presc_clr;
  logic cp_on;
  logic cp_bad;
  logic bus_req;
  logic [31:0] status_word;

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  // Fuses are sampled every cycle; a change while running takes effect one cycle later
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_r <= '0;
    end else begin
      cfg_r <= spcd_pkg::spcd_cfg_t'(CONFIG_WORD); // RL13
    end
  end

  assign OSC_MODE = cfg_r.osc; // RL16
  assign OSC_SELECT_INVALID = (cfg_r.osc == spcd_pkg::OSC_INVALID); // RL16
  assign CLOCK_OUTPUT_EN = (cfg_r.osc == spcd_pkg::OSC_INT_RC_CLOCK_OUTPUT_FUNCTION) ||
                           (cfg_r.osc == spcd_pkg::OSC_EXT_RC_CLOCK_OUTPUT_FUNCTION); // RL16
  assign crystal = (cfg_r.osc == spcd_pkg::OSC_LP_XTAL) ||
                   (cfg_r.osc == spcd_pkg::OSC_STD_XTAL) ||
                   (cfg_r.osc == spcd_pkg::OSC_HS_XTAL); // RL16
  // Clock input may come from a crystal or an external source alike
  assign CRYSTAL_MODE = crystal; // RL20
  assign RESET_PIN_IO = !cfg_r.master_clear_input_en; // RL14
  // Disabled pin function reads as an inactive reset input
  assign master_clear_input_active = cfg_r.master_clear_input_en && !MASTER_CLEAR_N_PIN; // RL14
  assign cp_on = ({cfg_r.cp_hi, cfg_r.cp_lo} == spcd_pkg::CP_ALL_ZERO);
  // Mixed protection bits are flagged; the programmer must avoid them
  assign cp_bad = !cp_on && ({cfg_r.cp_hi, cfg_r.cp_lo} != spcd_pkg::CP_ALL_ONE); // RL17

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      user_ok_r <= 1'b0;
      prog_ok_r <= 1'b0;
    end else begin
      user_ok_r <= (USER_ADDR != spcd_pkg::CFG_ADDR); // RL18
      prog_ok_r <= !cp_on || (PROG_ADDR == spcd_pkg::CAL_ADDR); // RL19
    end
  end

  assign USER_ADDR_OK = user_ok_r;
  assign PROG_READ_OK = prog_ok_r;

  // ----------------------------------------------------------------
  // Reset sequencing and startup delay
  // ----------------------------------------------------------------
  assign run = (state_r == spcd_pkg::ST_RUN);

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= spcd_pkg::ST_HOLD;
      por_r <= 1'b1;
      drt_cnt_r <= '0;
    end else begin
      case (state_r)
        spcd_pkg::ST_HOLD: begin
          drt_cnt_r <= '0;
          if (!master_clear_input_active) begin
            // RC modes skip the delay once power-up is behind them
            if (por_r || crystal) begin
              state_r <= spcd_pkg::ST_DELAY; // RL11
            end else begin
              state_r <= spcd_pkg::ST_RUN; // RL11
            end
          end
        end
        spcd_pkg::ST_DELAY: begin
          if (master_clear_input_active) begin
            state_r <= spcd_pkg::ST_HOLD;
          end else if (drt_cnt_r == DRT_W'(DRT_CYCLES - 1)) begin
            state_r <= spcd_pkg::ST_RUN; // RL11
            por_r <= 1'b0;
          end else begin
            drt_cnt_r <= drt_cnt_r + 1'b1;
          end
        end
        spcd_pkg::ST_RUN: begin
          // A timeout while awake is a device reset, asleep it is a wake
          if (master_clear_input_active || (wdt_evt && !sleep_r)) begin
            state_r <= spcd_pkg::ST_HOLD;
          end
        end
        default: begin
          state_r <= spcd_pkg::ST_HOLD;
        end
      endcase
    end
  end

  assign CHIP_RESET_N = run;

  // ----------------------------------------------------------------
  // Option register and bus slave
  // ----------------------------------------------------------------
  // One wait state: read data is set up while waitrequest is high
  assign bus_req = AVS_READ || AVS_WRITE;
  assign AVS_WAITREQUEST = bus_req && !ack_r;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req && !ack_r;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      opt_r <= spcd_pkg::OPT_RESET;
    end else if (!run) begin
      opt_r <= spcd_pkg::OPT_RESET;
    end else if (AVS_WRITE && ack_r && AVS_BYTEENABLE[0] &&
                 AVS_ADDRESS == spcd_pkg::REG_OPTION) begin
      opt_r <= spcd_pkg::spcd_opt_t'(AVS_WRITEDATA[7:0]); // RL2 RL7
    end
  end

  always_comb begin
    status_word = '0;
    status_word[spcd_pkg::STAT_ASSIGN] = opt_r.assign_wdt;
    status_word[spcd_pkg::STAT_SLEEP] = sleep_r;
    status_word[spcd_pkg::STAT_RESET] = !run;
    status_word[spcd_pkg::STAT_DELAY] = (state_r == spcd_pkg::ST_DELAY);
    status_word[spcd_pkg::STAT_WDT_ON] = wdt_on;
    status_word[spcd_pkg::STAT_CP_BAD] = cp_bad;
  end

  // The shared counter itself has no address at all
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_r <= '0;
    end else if (AVS_READ && !ack_r) begin
      case (AVS_ADDRESS)
        spcd_pkg::REG_OPTION: rdata_r <= {24'h000000, opt_r};
        spcd_pkg::REG_STATUS: rdata_r <= status_word; // RL5
        default: rdata_r <= '0;
      endcase
    end
  end

  assign AVS_READDATA = rdata_r;

  // ----------------------------------------------------------------
  // Watchdog on its own RC rate
  // ----------------------------------------------------------------
  // The RC oscillator is modelled as an enable from a divider
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rc_div_r <= '0;
    end else if (rc_div_r == RC_W'(WDT_RC_DIV - 1)) begin
      rc_div_r <= '0;
    end else begin
      rc_div_r <= rc_div_r + 1'b1;
    end
  end

  assign rc_tick = (rc_div_r == RC_W'(WDT_RC_DIV - 1)); // RL10
  assign wdt_on = cfg_r.wdt_en && run; // RL10 RL15
  assign wdt_ovf = rc_tick && wdt_on && (wdt_cnt_r == WDT_CNT_W'(WDT_BASE_TICKS - 1));
  assign WDT_ACTIVE = wdt_on;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wdt_cnt_r <= '0;
    end else if (!wdt_on || WATCHDOG_CLEAR_INSTR || wdt_ovf) begin
      wdt_cnt_r <= '0; // RL4
    end else if (rc_tick) begin
      wdt_cnt_r <= wdt_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Shared counter
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= TIMER_PIN;
    end
  end

  assign timer_src = opt_r.src_pin ?
                     (opt_r.src_fall ? (pin_prev_r && !TIMER_PIN) : (!pin_prev_r && TIMER_PIN)) :
                     INSTR_TICK;
  // Only the owner feeds the counter; the other unit bypasses it
  assign presc_evt = opt_r.assign_wdt ? wdt_ovf : timer_src; // RL1 RL2
  assign presc_mask = opt_r.assign_wdt ?
                      (spcd_pkg::WDT_MASK_FULL >> (spcd_pkg::RATIO_MAX - opt_r.ratio)) :
                      (spcd_pkg::TMR_MASK_FULL >> (spcd_pkg::RATIO_MAX - opt_r.ratio)); // RL22 RL21
  assign presc_tc = ((presc_r & presc_mask) == presc_mask);
  assign presc_clr = opt_r.assign_wdt ? WATCHDOG_CLEAR_INSTR : TIMER_COUNT_WRITE; // RL3 RL4
  assign wdt_evt = wdt_ovf && (!opt_r.assign_wdt || presc_tc);

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      presc_r <= spcd_pkg::PRESC_ZERO; // RL6
    end else if (!run) begin
      presc_r <= spcd_pkg::PRESC_ZERO; // RL6
    end else if (presc_clr) begin
      presc_r <= spcd_pkg::PRESC_ZERO; // RL3 RL4
    end else if (presc_evt) begin
      presc_r <= presc_r + 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tinc_r <= 1'b0;
      wto_r <= 1'b0;
    end else begin
      tinc_r <= run && timer_src && (opt_r.assign_wdt || presc_tc); // RL1 RL21
      wto_r <= wdt_evt;
    end
  end

  assign TIMER_INC = tinc_r;
  assign WDT_TIMEOUT = wto_r;

  // ----------------------------------------------------------------
  // Sleep and wake
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sleep_r <= 1'b0;
      wake_r <= 1'b0;
    end else if (!run) begin
      sleep_r <= 1'b0;
      wake_r <= 1'b0;
    end else if (sleep_r && (PIN_CHANGE || wdt_evt)) begin
      sleep_r <= 1'b0; // RL12
      wake_r <= 1'b1;
    end else begin
      sleep_r <= sleep_r || SLEEP_ENTER;
      wake_r <= 1'b0;
    end
  end

  assign SLEEPING = sleep_r;
  assign WAKE = wake_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  property p_tmr_clear;
    run && !opt_r.assign_wdt && TIMER_COUNT_WRITE |=> presc_r == spcd_pkg::PRESC_ZERO;
  endproperty
  a_tmr_clear: assert property (p_tmr_clear) else $error("Timer write left counter nonzero"); // RL3

  property p_wdt_clear;
    run && opt_r.assign_wdt && WATCHDOG_CLEAR_INSTR |=>
      presc_r == spcd_pkg::PRESC_ZERO && wdt_cnt_r == '0;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("Watchdog clear missed a counter"); // RL4

  property p_reset_zero;
    !run |=> presc_r == spcd_pkg::PRESC_ZERO;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("Counter nonzero after reset"); // RL6

  property p_owner_bypass;
    run && opt_r.assign_wdt && timer_src |=> TIMER_INC;
  endproperty
  a_owner_bypass: assert property (p_owner_bypass) else $error("Timer divided while watchdog owns"); // RL1

  property p_min_ratio;
    run && !opt_r.assign_wdt && timer_src && !presc_r[0] |=> !TIMER_INC;
  endproperty
  a_min_ratio: assert property (p_min_ratio) else $error("Timer ratio below 1:2"); // RL21

  property p_fuse_off;
    !cfg_r.wdt_en |=> !WDT_TIMEOUT && wdt_cnt_r == '0;
  endproperty
  a_fuse_off: assert property (p_fuse_off) else $error("Watchdog ran with fuse off"); // RL10

  property p_rc_no_delay;
    state_r == spcd_pkg::ST_HOLD && !master_clear_input_active && !por_r && !crystal |=> run;
  endproperty
  a_rc_no_delay: assert property (p_rc_no_delay) else $error("RC mode delayed a later reset"); // RL11

  property p_xtal_delay;
    state_r == spcd_pkg::ST_HOLD && !master_clear_input_active && crystal |=>
      state_r == spcd_pkg::ST_DELAY ##1 !CHIP_RESET_N;
  endproperty
  a_xtal_delay: assert property (p_xtal_delay) else $error("Crystal reset skipped delay"); // RL11

  property p_wake;
    run && sleep_r && PIN_CHANGE && !master_clear_input_active |=> !SLEEPING && WAKE;
  endproperty
  a_wake: assert property (p_wake) else $error("Pin change did not wake"); // RL12

  property p_pin_io;
    run && !cfg_r.master_clear_input_en && !wdt_evt && !MASTER_CLEAR_N_PIN |=> run;
  endproperty
  a_pin_io: assert property (p_pin_io) else $error("I/O pin caused a reset"); // RL14

  property p_cfg_hidden;
    USER_ADDR == spcd_pkg::CFG_ADDR |=> !USER_ADDR_OK;
  endproperty
  a_cfg_hidden: assert property (p_cfg_hidden) else $error("Config word reachable by code"); // RL18

  property p_cal_open;
    PROG_ADDR == spcd_pkg::CAL_ADDR |=> PROG_READ_OK;
  endproperty
  a_cal_open: assert property (p_cal_open) else $error("Calibration word protected"); // RL19

endmodule // spcd_top

// [src/spcd_pkg.sv]
package spcd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int DRT_TIME_US = 18000;
  // Nominal delay, rounded down to whole clock cycles
  localparam int DRT_CYCLES_DFLT = (DRT_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int WDT_RC_DIV_DFLT = 32;
  localparam int WDT_BASE_TICKS_DFLT = 256;

  // ----------------------------------------------------------------
  // Shared counter and option word
  // ----------------------------------------------------------------
  localparam int PRESC_W = 8;
  localparam logic [7:0] PRESC_ZERO = 8'h00;
  localparam logic [7:0] TMR_MASK_FULL = 8'hFF;
  localparam logic [7:0] WDT_MASK_FULL = 8'h7F;
  localparam logic [2:0] RATIO_MAX = 3'h7;
  localparam logic [7:0] OPT_RESET = 8'hFF;

  // ----------------------------------------------------------------
  // Configuration word and address map
  // ----------------------------------------------------------------
  localparam int CFG_W = 12;
  localparam int PADDR_W = 12;
  localparam logic [11:0] CFG_ADDR = 12'hFFF;
  localparam logic [11:0] CAL_ADDR = 12'h3FF;
  localparam logic [6:0] CP_ALL_ZERO = 7'h00;
  localparam logic [6:0] CP_ALL_ONE = 7'h7F;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int AVS_ADDR_W = 4;
  localparam logic [3:0] REG_OPTION = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int STAT_ASSIGN = 0;
  localparam int STAT_SLEEP = 1;
  localparam int STAT_RESET = 2;
  localparam int STAT_DELAY = 3;
  localparam int STAT_WDT_ON = 4;
  localparam int STAT_CP_BAD = 5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OSC_LP_XTAL = 3'h0,
    OSC_STD_XTAL = 3'h1,
    OSC_HS_XTAL = 3'h2,
    OSC_INVALID = 3'h3,
    OSC_INT_RC_IO = 3'h4,
    OSC_INT_RC_CLOCK_OUTPUT_FUNCTION = 3'h5,
    OSC_EXT_RC_IO = 3'h6,
    OSC_EXT_RC_CLOCK_OUTPUT_FUNCTION = 3'h7
  } spcd_osc_t;

  typedef enum logic [1:0] {
    ST_HOLD = 2'h0,
    ST_DELAY = 2'h1,
    ST_RUN = 2'h2
  } spcd_rst_t;

  // Layout follows configuration bits 11..0
  typedef struct packed {
    logic [5:0] cp_hi;
    logic master_clear_input_en;
    logic cp_lo;
    logic wdt_en;
    spcd_osc_t osc;
  } spcd_cfg_t;

  // Layout follows option bits 7..0
  typedef struct packed {
    logic [1:0] wake_pull;
    logic src_pin;
    logic src_fall;
    logic assign_wdt;
    logic [2:0] ratio;
  } spcd_opt_t;

endpackage

// [tb/shared_prescaler_and_config_decode_tb.sv]
`timescale 1ns/1ps

module shared_prescaler_and_config_decode_tb;
  // ----------------------------------------------------------------
  // Clock, reset and stimulus
  // ----------------------------------------------------------------
  localparam int STARTUP_DELAY_TIMER = 20;
  localparam int LIMIT = 20000;
  logic CORE_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [3:0] AVS_ADDRESS = 4'h0;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic [11:0] CONFIG_WORD = 12'hFF1;
  logic INSTR_TICK = 1'b0;
  logic TIMER_PIN = 1'b0;
  logic TIMER_COUNT_WRITE = 1'b0;
  logic WATCHDOG_CLEAR_INSTR = 1'b0;
  logic SLEEP_ENTER = 1'b0;
  logic PIN_CHANGE = 1'b0;
  logic MASTER_CLEAR_N_PIN = 1'b1;
  logic [11:0] USER_ADDR = 12'h000;
  logic [11:0] PROG_ADDR = 12'h000;
  logic TIMER_INC, WDT_TIMEOUT, CHIP_RESET_N, SLEEPING, WAKE;
  logic OSC_SELECT_INVALID, CLOCK_OUTPUT_EN, CRYSTAL_MODE, RESET_PIN_IO, WDT_ACTIVE;
  logic USER_ADDR_OK, PROG_READ_OK;
  spcd_pkg::spcd_osc_t OSC_MODE;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int inc_seen = 0;
  int wdt_seen = 0;
  int wake_seen = 0;
  // Behavioural model state
  int cnt_m = 0;
  int exp_inc = 0;
  int opt_m = 0;
  int c, b0, b1;
  logic [31:0] rd;

  initial begin
    forever #4 CORE_CLK = ~CORE_CLK;
  end

  spcd_top #(.DRT_CYCLES(STARTUP_DELAY_TIMER), .WDT_RC_DIV(2), .WDT_BASE_TICKS(4), .WDT_CNT_W(8)) dut (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .CONFIG_WORD(CONFIG_WORD),
    .INSTR_TICK(INSTR_TICK), .TIMER_PIN(TIMER_PIN), .TIMER_COUNT_WRITE(TIMER_COUNT_WRITE),
    .WATCHDOG_CLEAR_INSTR(WATCHDOG_CLEAR_INSTR), .SLEEP_ENTER(SLEEP_ENTER), .PIN_CHANGE(PIN_CHANGE),
    .MASTER_CLEAR_N_PIN(MASTER_CLEAR_N_PIN), .USER_ADDR(USER_ADDR), .PROG_ADDR(PROG_ADDR),
    .TIMER_INC(TIMER_INC), .WDT_TIMEOUT(WDT_TIMEOUT), .CHIP_RESET_N(CHIP_RESET_N), .SLEEPING(SLEEPING),
    .WAKE(WAKE), .OSC_MODE(OSC_MODE), .OSC_SELECT_INVALID(OSC_SELECT_INVALID),
    .CLOCK_OUTPUT_EN(CLOCK_OUTPUT_EN), .CRYSTAL_MODE(CRYSTAL_MODE), .RESET_PIN_IO(RESET_PIN_IO),
    .WDT_ACTIVE(WDT_ACTIVE), .USER_ADDR_OK(USER_ADDR_OK), .PROG_READ_OK(PROG_READ_OK)
  );

  // ----------------------------------------------------------------
  // Event counters and hang guard
  // ----------------------------------------------------------------
  always @(posedge CORE_CLK) begin
    cyc++;
    if (TIMER_INC === 1'b1) inc_seen++;
    if (WDT_TIMEOUT === 1'b1) wdt_seen++;
    if (WAKE === 1'b1) wake_seen++;
    if (cyc == LIMIT) begin
      n_fail++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Waitrequest and read data are taken at the rising edge that ends the request
  task automatic wait_ack();
    do @(posedge CORE_CLK); while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h0, d};
    AVS_WRITE <= 1'b1;
    wait_ack();
    AVS_WRITE <= 1'b0;
    if (a == spcd_pkg::REG_OPTION) opt_m = d;
  endtask

  task automatic bus_rd(input logic [3:0] a);
    @(posedge CORE_CLK);
    AVS_ADDRESS <= a;
    AVS_READ <= 1'b1;
    wait_ack();
    AVS_READ <= 1'b0;
  endtask

  task automatic pulse(input int which);
    @(posedge CORE_CLK);
    case (which)
      0: TIMER_COUNT_WRITE <= 1'b1;
      1: WATCHDOG_CLEAR_INSTR <= 1'b1;
      2: SLEEP_ENTER <= 1'b1;
      default: PIN_CHANGE <= 1'b1;
    endcase
    @(posedge CORE_CLK);
    TIMER_COUNT_WRITE <= 1'b0;
    WATCHDOG_CLEAR_INSTR <= 1'b0;
    SLEEP_ENTER <= 1'b0;
    PIN_CHANGE <= 1'b0;
  endtask

  // Ticks are back to back; the model divides by two to the power ratio plus one
  task automatic ticks(input int n, input int r);
    for (int i = 0; i < n; i++) begin
      @(posedge CORE_CLK);
      INSTR_TICK <= 1'b1;
      cnt_m++;
      if (cnt_m == (1 << (r + 1))) begin
        cnt_m = 0;
        exp_inc++;
      end
    end
    @(posedge CORE_CLK);
    INSTR_TICK <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
  endtask

  task automatic wait_run(output int n);
    n = 0;
    while (CHIP_RESET_N !== 1'b1 && n < 5000) begin
      @(posedge CORE_CLK);
      n++;
    end
  endtask

  task automatic pin_reset(input logic [11:0] cfg, output int n);
    @(posedge CORE_CLK);
    CONFIG_WORD <= cfg;
    repeat (3) @(posedge CORE_CLK);
    MASTER_CLEAR_N_PIN <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    MASTER_CLEAR_N_PIN <= 1'b1;
    wait_run(n);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(43));
    repeat (3) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    wait_run(c);
    check("startup delay", c >= STARTUP_DELAY_TIMER && c <= STARTUP_DELAY_TIMER + 4, 1);
    opt_m = spcd_pkg::OPT_RESET;
    bus_rd(spcd_pkg::REG_OPTION);
    check("option after reset", rd, opt_m);
    // Timer owner: every ratio, plus clear on timer register write
    for (int r = 0; r < 8; r++) begin
      bus_wr(spcd_pkg::REG_OPTION, 8'(r));
      pulse(0);
      cnt_m = 0;
      b0 = inc_seen;
      exp_inc = 0;
      ticks(2 * (1 << (r + 1)) + ($urandom % (1 << (r + 1))), r);
      check("timer increments", inc_seen - b0, exp_inc);
      pulse(0);
      cnt_m = 0;
      b0 = inc_seen;
      exp_inc = 0;
      ticks((1 << (r + 1)) - 1, r);
      check("no increment after clear", inc_seen - b0, 0);
      ticks(1, r);
      check("increment at ratio", inc_seen - b0, 1);
    end
    // Handover to watchdog with the interim option value
    bus_wr(spcd_pkg::REG_OPTION, 8'h01);
    pulse(1);
    pulse(0);
    bus_wr(spcd_pkg::REG_OPTION, 8'h0F);
    pulse(1);
    bus_wr(spcd_pkg::REG_OPTION, 8'h0A);
    bus_rd(spcd_pkg::REG_STATUS);
    check("owner bit", rd[spcd_pkg::STAT_ASSIGN], 1'b1);
    bus_wr(spcd_pkg::REG_STATUS, 8'h00);
    bus_rd(spcd_pkg::REG_OPTION);
    check("option readback", rd, opt_m);
    bus_rd(4'h8);
    check("unmapped read", rd, 0);
    // Watchdog on: clears keep it quiet
    @(posedge CORE_CLK);
    CONFIG_WORD <= 12'hFF9;
    WATCHDOG_CLEAR_INSTR <= 1'b1;
    @(posedge CORE_CLK);
    WATCHDOG_CLEAR_INSTR <= 1'b0;
    b1 = wdt_seen;
    repeat (12) begin
      repeat (14) @(posedge CORE_CLK);
      pulse(1);
    end
    check("watchdog active", WDT_ACTIVE, 1'b1);
    check("no timeout while cleared", wdt_seen - b1, 0);
    // Timeout in sleep wakes without reset
    pulse(2);
    repeat (2) @(posedge CORE_CLK);
    check("sleeping", SLEEPING, 1'b1);
    b0 = wake_seen;
    c = 0;
    while (wake_seen == b0 && c < 80) begin
      @(posedge CORE_CLK);
      c++;
    end
    repeat (2) @(posedge CORE_CLK);
    check("watchdog wake", wake_seen - b0, 1);
    check("still running", CHIP_RESET_N, 1'b1);
    // Timeout while awake, after a clear: ratio 2 gives four overflows of eight cycles
    pulse(1);
    b1 = wdt_seen;
    c = 0;
    while (wdt_seen == b1 && c < 100) begin
      @(posedge CORE_CLK);
      c++;
    end
    check("timeout period", c >= 24 && c <= 44, 1);
    CONFIG_WORD <= 12'hFF1;
    repeat (2) @(posedge CORE_CLK);
    check("watchdog reset", CHIP_RESET_N, 1'b0);
    opt_m = spcd_pkg::OPT_RESET;
    wait_run(c);
    bus_rd(spcd_pkg::REG_OPTION);
    check("option after device reset", rd, opt_m);
    // Fuse off keeps the watchdog silent, then back to timer
    bus_wr(spcd_pkg::REG_OPTION, 8'h08);
    b1 = wdt_seen;
    repeat (100) @(posedge CORE_CLK);
    check("fuse off silent", wdt_seen - b1, 0);
    check("watchdog inactive", WDT_ACTIVE, 1'b0);
    pulse(1);
    bus_wr(spcd_pkg::REG_OPTION, 8'h00);
    // Pin change wake
    pulse(2);
    b0 = wake_seen;
    pulse(3);
    repeat (3) @(posedge CORE_CLK);
    check("pin wake", wake_seen - b0, 1);
    check("awake", SLEEPING, 1'b0);
    // Pin source on falling edges, ratio 1:2: four edges give two increments
    bus_wr(spcd_pkg::REG_OPTION, 8'h30);
    pulse(0);
    b0 = inc_seen;
    repeat (4) begin
      @(posedge CORE_CLK);
      TIMER_PIN <= 1'b1;
      @(posedge CORE_CLK);
      TIMER_PIN <= 1'b0;
    end
    repeat (3) @(posedge CORE_CLK);
    check("pin source increments", inc_seen - b0, 2);
    // Reset pin and startup delay per oscillator family
    pin_reset(12'hFF1, c);
    check("crystal delay", c >= STARTUP_DELAY_TIMER, 1);
    pin_reset(12'hFF4, c);
    check("rc no delay", c < STARTUP_DELAY_TIMER, 1);
    @(posedge CORE_CLK);
    CONFIG_WORD <= 12'hFD1;
    // Fuse must be in place before the pin drops, or the old fuse resets
    @(posedge CORE_CLK);
    MASTER_CLEAR_N_PIN <= 1'b0;
    repeat (5) @(posedge CORE_CLK);
    check("pin ignored", CHIP_RESET_N, 1'b1);
    check("pin is io", RESET_PIN_IO, 1'b1);
    MASTER_CLEAR_N_PIN <= 1'b1;
    // Oscillator field decode
    for (int o = 0; o < 8; o++) begin
      @(posedge CORE_CLK);
      CONFIG_WORD <= {6'h3F, 1'b1, 1'b1, 1'b0, 3'(o)};
      repeat (3) @(posedge CORE_CLK);
      check("osc mode", OSC_MODE, o);
      check("osc invalid", OSC_SELECT_INVALID, o == 3);
      check("clock out", CLOCK_OUTPUT_EN, o == 5 || o == 7);
      check("crystal", CRYSTAL_MODE, o < 3);
      check("pin function", RESET_PIN_IO, 1'b0);
    end
    // Address map and protection
    c = $urandom % 4095;
    @(posedge CORE_CLK);
    CONFIG_WORD <= 12'h021;
    USER_ADDR <= 12'hFFF;
    PROG_ADDR <= 12'h3FF;
    repeat (3) @(posedge CORE_CLK);
    check("config hidden", USER_ADDR_OK, 1'b0);
    check("calibration open", PROG_READ_OK, 1'b1);
    USER_ADDR <= 12'(c);
    PROG_ADDR <= (c == 12'h3FF) ? 12'h000 : 12'(c);
    repeat (3) @(posedge CORE_CLK);
    check("user address", USER_ADDR_OK, 1'b1);
    check("protected", PROG_READ_OK, 1'b0);
    CONFIG_WORD <= 12'hFF1;
    repeat (3) @(posedge CORE_CLK);
    check("unprotected", PROG_READ_OK, 1'b1);
    give_verdict();
  end
endmodule // shared_prescaler_and_config_decode_tb
